// >>> design/sls_pkg.sv
// Package for the servo limit supervisor: register map, fields, resets
package sls_pkg;
  // Command codes kept for reference by software
  localparam logic [7:0] SLS_CMD_ERR_LIM    = 8'h97;
  localparam logic [7:0] SLS_CMD_NEG_TRAVEL = 8'h43;
  localparam logic [7:0] SLS_CMD_POS_TRAVEL = 8'h42;
  localparam logic [7:0] SLS_CMD_FILT_CFG   = 8'ha9;
  // Register word addresses (byte address = 4 * index)
  localparam logic [4:0] SLS_REG_MOVE_LIM  = 5'h00;
  localparam logic [4:0] SLS_REG_HOLD_LIM  = 5'h01;
  localparam logic [4:0] SLS_REG_HOLD_DLY  = 5'h02;
  localparam logic [4:0] SLS_REG_NEG_BASE  = 5'h04;
  localparam logic [4:0] SLS_REG_POS_BASE  = 5'h0a;
  localparam logic [4:0] SLS_REG_FILT_BASE = 5'h10;
  localparam logic [4:0] SLS_REG_STATUS    = 5'h14;
  localparam logic [4:0] SLS_REG_TARGET    = 5'h15;
  localparam int         SLS_MASK_REGS     = 6;
  localparam int         SLS_FILT_REGS     = 3;
  // Status fields
  localparam int SLS_ST_MOVE_ERR = 0;
  localparam int SLS_ST_HOLD_ERR = 1;
  localparam int SLS_ST_HOLDING  = 2;
  localparam int SLS_ST_NEG_BLK  = 3;
  localparam int SLS_ST_POS_BLK  = 4;
  localparam int SLS_ST_PEND     = 5;
  // Reset values and ranges
  localparam logic [15:0] SLS_RST_LIMIT = 16'h0000;
  localparam logic [15:0] SLS_RST_DELAY = 16'h0064;
  localparam logic [15:0] SLS_RST_FILT  = 16'h7fff;
  localparam logic [15:0] SLS_FILT_MIN  = 16'h1000;
  localparam logic [15:0] SLS_FILT_MAX  = 16'h7fff;
  localparam logic [15:0] SLS_ZERO16    = 16'h0000;
  localparam logic [31:0] SLS_ZERO32    = 32'h0000_0000;
  localparam logic [31:0] SLS_BAD_READ  = 32'hdead_beef;

  // Absolute value of a signed limit, widened to avoid the -32768 corner
  function automatic logic [16:0] sls_abs(input logic signed [15:0] v);
    logic signed [16:0] w;
    w = 17'(v);
    return (w < 0) ? 17'(-w) : 17'(w);
  endfunction : sls_abs

  // Enabled-and-matching mask test over one status word
  function automatic logic sls_hit(input logic [15:0] st, input logic [15:0] en,
                                   input logic [15:0] lvl);
    return |(en & ~(st ^ lvl));
  endfunction : sls_hit
endpackage : sls_pkg

// >>> design/sls_travel_check.sv
// End-of-travel condition evaluator for one direction
`timescale 1ns/1ps
module sls_travel_check
  import sls_pkg::*;
(
  // Status words
  input  wire logic [15:0] status_word,
  input  wire logic [15:0] status_word_two,
  input  wire logic [15:0] ext_io_word,
  // Six masks: enable/state for each word
  input  wire logic [15:0] en0,
  input  wire logic [15:0] lv0,
  input  wire logic [15:0] en1,
  input  wire logic [15:0] lv1,
  input  wire logic [15:0] en2,
  input  wire logic [15:0] lv2,
  // Result
  output logic             active
);
  // Enable selects, state gives the blocking level, OR of all words
  assign active = sls_hit(status_word, en0, lv0) |
                  sls_hit(status_word_two, en1, lv1) |
                  sls_hit(ext_io_word, en2, lv2);
endmodule : sls_travel_check

// >>> design/sls_hold_timer.sv
// Delay-to-holding timer
`timescale 1ns/1ps
module sls_hold_timer
  import sls_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Control
  input  wire logic        moving,
  input  wire logic [15:0] delay_ticks,
  // Result
  output logic             holding
);
  logic [15:0] cnt_ff;
  logic        holding_ff;

  // Count ticks after motion stops; motion restarts the window
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_ff     <= SLS_ZERO16;
      holding_ff <= 1'b0;
    end else if (moving) begin
      cnt_ff     <= SLS_ZERO16;
      holding_ff <= 1'b0;
    end else if (!holding_ff) begin
      if (cnt_ff >= delay_ticks) begin
        holding_ff <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
    end
  end
  assign holding = holding_ff;

  chk_hold_after_delay: assert property (@(posedge clk) disable iff (reset)
    $rose(holding_ff) |-> $past(cnt_ff) >= $past(delay_ticks))
    else $error("holding entered before delay elapsed");
endmodule : sls_hold_timer

// >>> design/sls_supervisor.sv
// Servo limit supervisor top: error limits, drag clamp, end of travel, filters
//
// Added by the designer: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module sls_supervisor
  import sls_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // Avalon-MM slave
  input  wire logic [4:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  // Servo tick and motion state
  input  wire logic               servo_tick,
  input  wire logic               move_active,
  input  wire logic               profile_move,
  input  wire logic               move_terminate,
  // Positions
  input  wire logic signed [31:0] actual_pos,
  input  wire logic signed [31:0] req_target,
  input  wire logic               req_valid,
  // Status words for travel checks
  input  wire logic [15:0]        internal_status_word,
  input  wire logic [15:0]        internal_status_word_two,
  input  wire logic [15:0]        extended_io_word,
  // Outputs to the loop
  output logic signed [31:0]      target_pos,
  output logic                    holding_torque,
  output logic                    move_error,
  output logic                    hold_error,
  output logic                    neg_blocked,
  output logic                    pos_blocked,
  output logic                    move_pending,
  output logic [15:0]             velocity_filter_one,
  output logic [15:0]             velocity_filter_two,
  output logic [15:0]             accel_filter
);
  // Configuration storage
  logic [15:0]        move_lim_ff;
  logic [15:0]        hold_lim_ff;
  logic [15:0]        delay_ff;
  logic [15:0]        neg_mask_ff [SLS_MASK_REGS];
  logic [15:0]        pos_mask_ff [SLS_MASK_REGS];
  logic [15:0]        filt_ff     [SLS_FILT_REGS];
  logic signed [31:0] target_ff;
  logic               move_err_ff;
  logic               hold_err_ff;
  logic               pend_ff;
  logic [31:0]        rdata_ff;
  logic               ack_ff;
  logic               holding;
  logic               neg_act;
  logic               pos_act;
  logic [15:0]        lim_now;
  logic [16:0]        lim_abs;
  logic signed [32:0] err;
  logic [32:0]        err_abs;
  logic signed [32:0] nxt_target;
  logic signed [32:0] lim_s;
  logic               wr_hit;
  logic [15:0]        wdata16;
  logic [15:0]        status_bits;
  logic               blk_req;

  // One wait cycle per access so read data comes from a flop
  // The fixed wait keeps the read path to one flop at the cost of bus rate
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  // Writes land on the answer edge, when the master sees waitrequest low
  assign wr_hit          = avs_write & ack_ff;
  assign wdata16         = avs_writedata[15:0];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avs_read | avs_write) & ~ack_ff;
    end
  end

  // Limit and delay registers; limits default to zero (check off)
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      move_lim_ff <= SLS_RST_LIMIT;
      hold_lim_ff <= SLS_RST_LIMIT;
      delay_ff    <= SLS_RST_DELAY;
    end else if (wr_hit && avs_byteenable[1:0] == 2'h3) begin
      if (avs_address == SLS_REG_MOVE_LIM) begin
        move_lim_ff <= wdata16;
      end
      if (avs_address == SLS_REG_HOLD_LIM) begin
        hold_lim_ff <= wdata16;
      end
      if (avs_address == SLS_REG_HOLD_DLY) begin
        delay_ff <= wdata16;
      end
    end
  end

  // Travel masks, enable/state pairs per status word
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < SLS_MASK_REGS; i++) begin
        neg_mask_ff[i] <= SLS_ZERO16;
        pos_mask_ff[i] <= SLS_ZERO16;
      end
    end else if (wr_hit && avs_byteenable[1:0] == 2'h3) begin
      for (int i = 0; i < SLS_MASK_REGS; i++) begin
        if (avs_address == SLS_REG_NEG_BASE + 5'(i)) begin
          neg_mask_ff[i] <= wdata16;
        end
        if (avs_address == SLS_REG_POS_BASE + 5'(i)) begin
          pos_mask_ff[i] <= wdata16;
        end
      end
    end
  end

  // Filter coefficients; out-of-range writes are clamped into range
  // Clamping, not refusing, keeps the loop usable after a bad write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < SLS_FILT_REGS; i++) begin
        filt_ff[i] <= SLS_RST_FILT;
      end
    end else if (wr_hit && avs_byteenable[1:0] == 2'h3) begin
      for (int i = 0; i < SLS_FILT_REGS; i++) begin
        if (avs_address == SLS_REG_FILT_BASE + 5'(i)) begin
          if (wdata16 < SLS_FILT_MIN) begin
            filt_ff[i] <= SLS_FILT_MIN;
          end else if (wdata16 > SLS_FILT_MAX) begin
            filt_ff[i] <= SLS_FILT_MAX;
          end else begin
            filt_ff[i] <= wdata16;
          end
        end
      end
    end
  end
  assign velocity_filter_one = filt_ff[0];
  assign velocity_filter_two = filt_ff[1];
  assign accel_filter        = filt_ff[2];

  // Delay-to-holding timer; counts clock cycles, each taken as one servo tick
  // A slower tick would need the count gated by servo_tick
  sls_hold_timer u_timer (
    .clk         (clk),
    .reset       (reset),
    .moving      (move_active),
    .delay_ticks (delay_ff),
    .holding     (holding)
  );
  assign holding_torque = holding;

  // Negative and positive travel checks
  // Both read the live status inputs, so a block acts on the very next tick
  sls_travel_check u_neg (
    .status_word     (internal_status_word),
    .status_word_two (internal_status_word_two),
    .ext_io_word     (extended_io_word),
    .en0 (neg_mask_ff[0]), .lv0 (neg_mask_ff[1]),
    .en1 (neg_mask_ff[2]), .lv1 (neg_mask_ff[3]),
    .en2 (neg_mask_ff[4]), .lv2 (neg_mask_ff[5]),
    .active          (neg_act)
  );
  sls_travel_check u_pos (
    .status_word     (internal_status_word),
    .status_word_two (internal_status_word_two),
    .ext_io_word     (extended_io_word),
    .en0 (pos_mask_ff[0]), .lv0 (pos_mask_ff[1]),
    .en1 (pos_mask_ff[2]), .lv1 (pos_mask_ff[3]),
    .en2 (pos_mask_ff[4]), .lv2 (pos_mask_ff[5]),
    .active          (pos_act)
  );
  assign neg_blocked = neg_act;
  assign pos_blocked = pos_act;

  // Limit in force and error magnitude
  assign lim_now = holding ? hold_lim_ff : move_lim_ff;
  assign lim_abs = sls_abs(lim_now);
  // Signed copy keeps the clamp arithmetic signed for negative positions
  assign lim_s   = 33'(lim_abs);
  assign err     = 33'(req_target) - 33'(actual_pos);
  assign err_abs = (err < 0) ? 33'(-err) : 33'(err);

  // Next target: direction blocks first, then drag clamp
  // Positions near the 32-bit ends are not guarded; the clamp may wrap there
  always_comb begin
    nxt_target = 33'(target_ff);
    if (req_valid) begin
      if (req_target < target_ff && neg_act) begin
        nxt_target = 33'(target_ff);
      end else if (req_target > target_ff && pos_act) begin
        nxt_target = 33'(target_ff);
      end else begin
        nxt_target = 33'(req_target);
      end
    end
    if (lim_now[15] && lim_abs != 17'h0) begin
      if (nxt_target > 33'(actual_pos) + lim_s) begin
        nxt_target = 33'(actual_pos) + lim_s;
      end else if (nxt_target < 33'(actual_pos) - lim_s) begin
        nxt_target = 33'(actual_pos) - lim_s;
      end
    end
  end

  // Target updates once per servo tick
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      target_ff <= SLS_ZERO32;
    end else if (servo_tick) begin
      target_ff <= nxt_target[31:0];
    end
  end
  assign target_pos = target_ff;

  // Error status, evaluated per tick; zero limit means no check
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      move_err_ff <= 1'b0;
      hold_err_ff <= 1'b0;
    end else if (servo_tick) begin
      move_err_ff <= !holding && lim_abs != 17'h0 &&
                     err_abs > 33'(lim_abs);
      hold_err_ff <= holding && lim_abs != 17'h0 &&
                     err_abs > 33'(lim_abs);
    end
  end
  assign move_error = move_err_ff;
  assign hold_error = hold_err_ff;

  // Profile request that a travel block holds back this tick
  assign blk_req = profile_move && req_valid &&
                   ((req_target < target_ff && neg_act) ||
                    (req_target > target_ff && pos_act));

  // A blocked profile move stays pending until an unblocked tick or move_terminate; a block on the
  // same edge as a terminate wins, so a still-blocked request is not lost
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pend_ff <= 1'b0;
    end else if (servo_tick && blk_req) begin
      pend_ff <= 1'b1;
    end else if (move_terminate || servo_tick) begin
      pend_ff <= 1'b0;
    end
  end
  assign move_pending = pend_ff;

  // Status word as seen by software and other logic
  always_comb begin
    status_bits                  = SLS_ZERO16;
    status_bits[SLS_ST_MOVE_ERR] = move_err_ff;
    status_bits[SLS_ST_HOLD_ERR] = hold_err_ff;
    status_bits[SLS_ST_HOLDING]  = holding;
    status_bits[SLS_ST_NEG_BLK]  = neg_act;
    status_bits[SLS_ST_POS_BLK]  = pos_act;
    status_bits[SLS_ST_PEND]     = pend_ff;
  end

  // Read mux, captured during the wait cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_ff <= SLS_ZERO32;
    end else if (avs_read && !ack_ff) begin
      rdata_ff <= SLS_BAD_READ;
      if (avs_address == SLS_REG_MOVE_LIM) rdata_ff <= {16'h0000, move_lim_ff};
      if (avs_address == SLS_REG_HOLD_LIM) rdata_ff <= {16'h0000, hold_lim_ff};
      if (avs_address == SLS_REG_HOLD_DLY) rdata_ff <= {16'h0000, delay_ff};
      for (int i = 0; i < SLS_MASK_REGS; i++) begin
        if (avs_address == SLS_REG_NEG_BASE + 5'(i)) rdata_ff <= {16'h0000, neg_mask_ff[i]};
        if (avs_address == SLS_REG_POS_BASE + 5'(i)) rdata_ff <= {16'h0000, pos_mask_ff[i]};
      end
      for (int i = 0; i < SLS_FILT_REGS; i++) begin
        if (avs_address == SLS_REG_FILT_BASE + 5'(i)) rdata_ff <= {16'h0000, filt_ff[i]};
      end
      if (avs_address == SLS_REG_STATUS) rdata_ff <= {16'h0000, status_bits};
      if (avs_address == SLS_REG_TARGET) rdata_ff <= target_ff;
    end
  end
  assign avs_readdata = rdata_ff;

  // Checks
  // Pending in two steps: a held-back profile request, then the flag after that tick
  sequence seq_held_back;
    servo_tick && blk_req;
  endsequence
  sequence seq_cause_gone;
    servo_tick && !blk_req;
  endsequence

  chk_neg_block_holds: assert property (@(posedge clk) disable iff (reset)
    servo_tick && neg_act && !lim_now[15] |=> target_pos >= $past(target_pos))
    else $error("target moved negative while blocked");
  chk_pos_block_holds: assert property (@(posedge clk) disable iff (reset)
    servo_tick && pos_act && !lim_now[15] |=> target_pos <= $past(target_pos))
    else $error("target moved positive while blocked");
  chk_zero_limit_off: assert property (@(posedge clk) disable iff (reset)
    servo_tick && lim_abs == 17'h0 |=> !move_error && !hold_error)
    else $error("error flagged with zero limit");
  chk_move_err_set: assert property (@(posedge clk) disable iff (reset)
    servo_tick && !holding && lim_abs != 17'h0 && err_abs > 33'(lim_abs)
    |=> move_error)
    else $error("moving error not raised");
  chk_drag_clamp: assert property (@(posedge clk) disable iff (reset)
    servo_tick && lim_now[15] && lim_abs != 17'h0 |=>
    (33'(target_pos) - 33'($past(actual_pos))) <= $past(lim_s) &&
    (33'($past(actual_pos)) - 33'(target_pos)) <= $past(lim_s))
    else $error("drag clamp exceeded");
  chk_opposite_free: assert property (@(posedge clk) disable iff (reset)
    servo_tick && req_valid && neg_act && !pos_act && !lim_now[15]
    && req_target > target_ff |=> target_pos == $past(req_target))
    else $error("opposite direction wrongly blocked");
  chk_filter_range: assert property (@(posedge clk) disable iff (reset)
    accel_filter >= SLS_FILT_MIN && accel_filter <= SLS_FILT_MAX)
    else $error("filter coefficient out of range");
  chk_status_bits: assert property (@(posedge clk) disable iff (reset)
    status_bits[SLS_ST_HOLD_ERR] == hold_error && status_bits[SLS_ST_MOVE_ERR] == move_error)
    else $error("status word mismatch");

  // Holding side, velocity coefficients and pending
  chk_hold_err_set: assert property (@(posedge clk) disable iff (reset)
    servo_tick && holding && lim_abs != 17'h0 && err_abs > 33'(lim_abs)
    |=> hold_error)
    else $error("holding error not raised");
  chk_err_exclusive: assert property (@(posedge clk) disable iff (reset)
    !(move_error && hold_error))
    else $error("moving and holding errors raised together");
  chk_hold_stays: assert property (@(posedge clk) disable iff (reset)
    !move_active && holding |=> holding)
    else $error("holding dropped while motion stopped");
  chk_vel_filter_range: assert property (@(posedge clk) disable iff (reset)
    velocity_filter_one >= SLS_FILT_MIN && velocity_filter_one <= SLS_FILT_MAX &&
    velocity_filter_two >= SLS_FILT_MIN && velocity_filter_two <= SLS_FILT_MAX)
    else $error("velocity coefficient out of range");

  chk_pend_raise: assert property (@(posedge clk) disable iff (reset)
    seq_held_back |=> move_pending)
    else $error("blocked profile move not pending");
  chk_pend_drop: assert property (@(posedge clk) disable iff (reset)
    seq_cause_gone |=> !move_pending)
    else $error("pending kept after the block cleared");
endmodule : sls_supervisor

// >>> tb/sls_traj_model.sv
// Stand-in for the trajectory generator and position loop
`timescale 1ns/1ps
module sls_traj_model
  import sls_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // Bench control
  input  wire logic               fire,
  input  wire logic signed [31:0] step,
  input  wire logic signed [31:0] lag,
  input  wire logic signed [31:0] target_pos,
  // Motion inputs of the supervisor
  output logic                    servo_tick,
  output logic signed [31:0]      req_target,
  output logic                    req_valid,
  output logic signed [31:0]      actual_pos
);
  // One tick per request, one clock wide
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      servo_tick <= 1'b0;
    end else begin
      servo_tick <= fire;
    end
  end
  // Proposal and position track the live target, so a stale value never reaches a tick
  assign req_target = target_pos + step;
  assign actual_pos = target_pos + lag;
  // No kill path here, so expected slip never stops motion
  assign req_valid  = ~reset;
endmodule : sls_traj_model

// >>> tb/tb.sv
// Self-checking bench for the servo limit supervisor
`timescale 1ns/1ps
module tb;
  import sls_pkg::*;
  logic               clk, reset, avs_read, avs_write, avs_waitrequest, servo_tick, fire;
  logic               move_active, profile_move, move_terminate, req_valid, holding_torque;
  logic               move_error, hold_error, neg_blocked, pos_blocked, move_pending, hold_exp;
  logic [4:0]         avs_address;
  logic [3:0]         avs_byteenable;
  logic [31:0]        avs_writedata, avs_readdata;
  logic signed [31:0] actual_pos, req_target, target_pos, step, lag;
  logic [15:0]        internal_status_word, internal_status_word_two, extended_io_word;
  logic [15:0]        velocity_filter_one, velocity_filter_two, accel_filter;
  logic [15:0]        msk [12];
  int                 err_count, n_compared, exp_tgt, lim_mv, lim_hd, k, n;

  sls_supervisor sls_supervisor_i (.clk, .reset, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .servo_tick,
    .move_active, .profile_move, .move_terminate, .actual_pos, .req_target, .req_valid,
    .internal_status_word, .internal_status_word_two, .extended_io_word, .target_pos,
    .holding_torque, .move_error, .hold_error, .neg_blocked, .pos_blocked, .move_pending,
    .velocity_filter_one, .velocity_filter_two, .accel_filter);
  sls_traj_model sls_traj_model_i (.clk, .reset, .fire, .step, .lag, .target_pos,
    .servo_tick, .req_target, .req_valid, .actual_pos);

  // Free-running 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t register read %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t output %h expected %h", $time, got, exp);
    end
  endtask : chk_out

  // One bus access; entered just after a rising edge, held until waitrequest is low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    logic w;
    w = 1'b1;
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= ~wr;
    for (n = 0; n < 20 && w; n++) begin
      @(negedge clk);
      w = avs_waitrequest;
      q = avs_readdata;
      @(posedge clk);
    end
    if (w) begin
      err_count++;
      $display("MISMATCH t=%0t bus access never completed", $time);
      close_out();
    end
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic [3:0] be = 4'hf);
    logic [31:0] q;
    bus(1'b1, a, {16'h0000, d}, be, q);
  endtask : wr

  task automatic rdchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, 4'hf, q);
    chk_reg(q & m, e);
  endtask : rdchk

  // Enabled bit at its active level in any of the three words
  function automatic logic blk(input int b);
    return |(msk[b] & ~(internal_status_word ^ msk[b+1]))
         | |(msk[b+2] & ~(internal_status_word_two ^ msk[b+3]))
         | |(msk[b+4] & ~(extended_io_word ^ msk[b+5]));
  endfunction : blk

  task automatic set_masks();
    for (k = 0; k < 12; k++) wr(5'(4 + k), msk[k]);
  endtask : set_masks

  // One servo tick, predicted from the limits and masks in force
  task automatic tick(input int s, input int lg);
    int l, a, d, act;
    logic stop;
    stop = (s < 0 && blk(0)) || (s > 0 && blk(6));
    act = exp_tgt + lg;
    l = hold_exp ? lim_hd : lim_mv;
    a = (l < 0) ? -l : l;
    d = (s < lg) ? lg - s : s - lg;
    if (!stop) exp_tgt = exp_tgt + s;
    if (l < 0 && exp_tgt > act + a) exp_tgt = act + a;
    if (l < 0 && exp_tgt < act - a) exp_tgt = act - a;
    step <= s;
    lag  <= lg;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk_out(target_pos, exp_tgt);
    chk_out(move_error, 32'(!hold_exp && l != 0 && d > a));
    chk_out(hold_error, 32'(hold_exp && l != 0 && d > a));
    chk_out(move_pending, 32'(profile_move && stop));
    @(posedge clk);
  endtask : tick

  // Holding must arrive after the programmed delay once motion stops
  task automatic hold_wait(input int d);
    wr(SLS_REG_HOLD_DLY, 16'(d));
    move_active <= 1'b0;
    for (n = 0; n < 300; n++) begin
      @(negedge clk);
      if (holding_torque === 1'b1) break;
      @(posedge clk);
    end
    chk_out(32'(n >= d && n <= d + 3), 32'h1);
    if (holding_torque !== 1'b1) close_out();
    @(posedge clk);
  endtask : hold_wait

  // Main sequence
  initial begin
    void'($urandom(24));
    {reset, avs_read, avs_write, fire, profile_move, move_terminate, hold_exp} = 7'h40;
    {avs_address, avs_byteenable, avs_writedata, step, lag} = '0;
    {internal_status_word, internal_status_word_two, extended_io_word} = '0;
    move_active = 1'b1;
    {err_count, n_compared, exp_tgt, lim_mv, lim_hd} = '0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rdchk(SLS_REG_MOVE_LIM, 32'hffff, 32'h0);
    rdchk(SLS_REG_HOLD_LIM, 32'hffff, 32'h0);
    rdchk(SLS_REG_HOLD_DLY, 32'hffff, 32'h64);
    rdchk(5'h1f, 32'hffff_ffff, SLS_BAD_READ);
    // Coefficients: 32768*exp(-2*pi*469Hz*120us) gives 23000, then range edges
    wr(SLS_REG_FILT_BASE, 16'd23000);
    wr(5'(SLS_REG_FILT_BASE + 1), 16'd4095);
    wr(5'(SLS_REG_FILT_BASE + 2), 16'd32767);
    wr(SLS_REG_FILT_BASE, 16'd5000, 4'h1);
    rdchk(SLS_REG_FILT_BASE, 32'hffff, 32'd23000);
    @(negedge clk);
    chk_out({velocity_filter_one, velocity_filter_two}, {16'd23000, 16'd4096});
    chk_out(32'(accel_filter), 32'd32767);
    @(posedge clk);
    // Sparse random masks against random status words
    for (int r = 0; r < 4; r++) begin
      for (k = 0; k < 12; k++) msk[k] = 16'($urandom & $urandom & $urandom);
      set_masks();
      rdchk(5'(4 + r), 32'hffff, 32'(msk[r]));
      for (int j = 0; j < 8; j++) begin
        {internal_status_word, internal_status_word_two} <= $urandom;
        extended_io_word <= 16'($urandom);
        @(negedge clk);
        chk_out({neg_blocked, pos_blocked}, {blk(0), blk(6)});
        @(posedge clk);
      end
    end
    // Directional blocks: word-one bit 5 low blocks negative, io bit 0 high blocks positive
    msk = '{16'h0020, 16'h0000, 16'h0, 16'h0, 16'h0, 16'h0,
            16'h0, 16'h0, 16'h0, 16'h0, 16'h0001, 16'h0001};
    set_masks();
    {internal_status_word, internal_status_word_two, extended_io_word} <= '0;
    @(posedge clk);
    wr(SLS_REG_MOVE_LIM, 16'd1000);
    lim_mv = 1000;
    tick(-10, 0);
    tick(10, 0);
    profile_move <= 1'b1;
    tick(-10, 0);
    move_terminate <= 1'b1;
    @(posedge clk);
    move_terminate <= 1'b0;
    @(negedge clk);
    chk_out(32'(move_pending), 32'h0);
    @(posedge clk);
    tick(-10, 0);
    internal_status_word <= 16'h0020;
    extended_io_word <= 16'h0001;
    @(posedge clk);
    tick(-10, 0);
    tick(10, 0);
    extended_io_word <= 16'h0000;
    profile_move <= 1'b0;
    @(posedge clk);
    tick(1500, 0);
    rdchk(SLS_REG_STATUS, 32'h3, 32'h1);
    tick(-900, 0);
    // Drag mode, including the widest negative limit
    wr(SLS_REG_MOVE_LIM, 16'hfc18);
    lim_mv = -1000;
    tick(1500, 0);
    tick(-1500, 0);
    tick(0, 2000);
    tick(300, 0);
    wr(SLS_REG_MOVE_LIM, 16'h8000);
    lim_mv = -32768;
    tick(40000, 0);
    wr(SLS_REG_MOVE_LIM, 16'h0000);
    lim_mv = 0;
    tick(5000, -3000);
    tick(-39868, 0);
    // Drag window straddling zero: negative target, positive upper bound
    wr(SLS_REG_MOVE_LIM, 16'hfc18);
    lim_mv = -1000;
    tick(-100, -100);
    // Switch to holding limits after the delay
    wr(SLS_REG_HOLD_LIM, 16'd30);
    lim_hd = 30;
    hold_wait(0);
    move_active <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk_out(32'(holding_torque), 32'h0);
    @(posedge clk);
    hold_wait(5);
    hold_exp = 1'b1;
    tick(40, 0);
    rdchk(SLS_REG_STATUS, 32'h7, 32'h6);
    tick(-20, 0);
    close_out();
  end
endmodule : tb
